// ---- design/mtc_cfg.svh ----
// Constants for the measurement trigger control block: register offsets,
// field positions, reset values and timing counts.
// Assumes inclusion by bare name from the design module and the testbench files.
`ifndef MTC_CFG_SVH
`define MTC_CFG_SVH

// Register byte offsets on the AHB-Lite bus.
`define MTC_OFS_CMD          12'h000
`define MTC_OFS_SRC          12'h004
`define MTC_OFS_MODE         12'h008
`define MTC_OFS_DELAY        12'h00C
`define MTC_OFS_HOLDOFF      12'h010
`define MTC_OFS_HYST         12'h014
`define MTC_OFS_LEVEL        12'h018
`define MTC_OFS_STATUS       12'h01C
`define MTC_OFS_ERROR        12'h020

// Command register bit positions (write one to issue).
`define MTC_CMD_ARM          0
`define MTC_CMD_IMM          1
`define MTC_CMD_GET          2
`define MTC_CMD_TRG          3
`define MTC_CMD_RESET        4
`define MTC_CMD_LOCAL        5
`define MTC_CMD_MEASCONF     6
`define MTC_CMD_ERRCLR       7

// Mode register bit positions.
`define MTC_MODE_CONT        0
`define MTC_MODE_SLOPE_NEG   1
`define MTC_MODE_SETTLE      2
`define MTC_MODE_SWEEP       3
`define MTC_MODE_RATE200     4
`define MTC_MODE_DET_AVG     5
`define MTC_MODE_SENS_AVG    6
`define MTC_MODE_ADJ_EXTINT  7
`define MTC_MODE_ADJ_AVG     8
`define MTC_MODE_SLAVED      9

// Reset values. Delay in 1.25 ns units, holdoff in 1 ns units,
// hysteresis in 0.05 dB units, level in 0.1 dBm units.
`define MTC_RST_DELAY        32'sh0000_0000
`define MTC_RST_HOLDOFF      32'h0000_03E8
`define MTC_HOLDOFF_MIN      32'h0000_03E8
`define MTC_HOLDOFF_MAX      32'h17D7_8400
`define MTC_DELAY_MAX        32'sh2FAF_0800
`define MTC_HYST_MAX         8'h3C
`define MTC_LEVEL_MIN        -16'sh0190
`define MTC_LEVEL_MAX        16'sh00C8
`define MTC_RST_HYST         8'h00
`define MTC_RST_LEVEL        16'sh0000

// Clock period in ps; delay unit 1250 ps, holdoff unit 1000 ps.
`define MTC_CLK_PS           40000
`define MTC_DELAY_UNIT_PS    1250
`define MTC_HOLD_UNIT_PS     1000
`define MTC_SETTLE_CYCLES    16'h0100
`define MTC_HIST_DEPTH       64

// Error codes, signed, as reported.
`define MTC_ERR_NONE         16'sh0000
`define MTC_ERR_TRIG_IGN     -16'sd211
`define MTC_ERR_CONFLICT     -16'sd221

`endif

// ---- design/mtc_pkg.sv ----
// Types for the measurement trigger control block.
// Assumes the constants header is available on the include path.
package mtc_pkg;
    // Trigger source selection codes.
    typedef enum logic [2:0] {
        SRC_ALWAYS, SRC_BUS, SRC_HOLD, SRC_EXT, SRC_CH1, SRC_CH2
    } mtc_src_type;

    typedef enum logic [1:0] {
        ST_IDLE, ST_WAIT, ST_DELAY, ST_MEASURE
    } mtc_state_type;

    // Level samples from both channels, 0.1 dBm units.
    typedef struct packed {
        logic signed [15:0] ch1;
        logic signed [15:0] ch2;
    } mtc_power_type;
endpackage : mtc_pkg

// ---- design/mtc_trigger.sv ----
// Trigger control for one measurement channel, with an AHB-Lite register slave.
// Assumes power samples arrive on sys_clk_i, one per cycle, and the external
// trigger pin is asynchronous.
//
// Notes on behaviour
// [R1] Immediate trigger fires at once only while waiting; result stored.
// [R2] Immediate trigger outside wait is dropped, error -211 posted.
// [R3] Writing the source never arms; arm command is separate.
// [R4] Bus source accepts GET, common trigger, or immediate trigger.
// [R5] External source takes the rear trigger input pin.
// [R6] Hold source ignores everything except immediate trigger.
// [R7] Always source: condition always met; free runs or one shot.
// [R8] Internal source qualifies on channel one or channel two level.
// [R9] Reset, power-up and local mode force source to always.
// [R10] Measure and configure commands set source to always.
// [R11] Host avoids read or measure with bus or hold source.
// [R12] Source query returns the selected source code.
// [R13] Master change to always/bus/hold while slaved: error -221.
// [R14] Internal/external with adjacent internal/external in other mode: -221.
// [R15] Internal/external while reading rate is 200: error -221.
// [R16] Internal/external while detector function averages: error -221.
// [R17] Signed delay between trigger and measurement, 1.25 ns units.
// [R18] Delay ignored in power or frequency sweep mode.
// [R19] Holdoff 1 us to 400 ms, 1 ns units, resets to 1 us.
// [R20] Holdoff ignored in sweep mode.
// [R21] Hysteresis must be crossed before the next edge is accepted.
// [R22] Power threshold -40 to 20 dBm, 0.1 dBm, resets to 0.
// [R23] Settling enable reads one when on, zero when off.
// [R24] Slope picks rising or falling crossings of the level.
// [R25] Continuous mode restarts a cycle at once without idle.
// [R26] Holdoff timed from each accepted event; events ignored meanwhile.
// [R27] Negative delay uses a pretrigger history of samples.
//
// The register addresses and register access over AHB-Lite are this design's own decisions.
`include "mtc_cfg.svh"

module mtc_trigger (
    input  wire logic                  sys_clk_i,
    input  wire logic                  reset_i,
    input  wire logic                  hsel_i,
    input  wire logic [11:0]           haddr_i,
    input  wire logic [1:0]            htrans_i,
    input  wire logic                  hwrite_i,
    input  wire logic [2:0]            hsize_i,
    input  wire logic [31:0]           hwdata_i,
    input  wire logic                  hready_i,
    output logic      [31:0]           hrdata_o,
    output logic                       hreadyout_o,
    output logic                       hresp_o,
    input  wire logic                  ext_trig_i,
    input  wire mtc_pkg::mtc_power_type power_i,
    input  wire logic                  meas_done_i,
    output logic                       meas_start_o,
    output logic signed [15:0]         meas_sample_o,
    output logic                       waiting_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    localparam int DLY_DIV = `MTC_CLK_PS / `MTC_DELAY_UNIT_PS;
    localparam int HLD_DIV = `MTC_CLK_PS / `MTC_HOLD_UNIT_PS;

    typedef struct packed {
        logic                  ext_s1;
        logic                  ext_s2;
        logic                  ext_d;
        logic                  wr_pend;
        logic [11:0]           wr_addr;
        logic [31:0]           rdata;
        mtc_pkg::mtc_src_type  src;
        logic [9:0]            mode;
        logic signed [31:0]    delay;
        logic [31:0]           holdoff;
        logic [7:0]            hyst;
        logic signed [15:0]    level;
        logic signed [15:0]    err;
        mtc_pkg::mtc_state_type st;
        logic                  armed_edge;
        logic [31:0]           cnt;
        logic [31:0]           hold_cnt;
        logic [5:0]            hist_ptr;
        logic [5:0]            tap;
        logic                  start;
        logic signed [15:0]    sample;
        logic                  stored;
    } mtc_state_reg_type;

    mtc_state_reg_type s_r;
    mtc_state_reg_type s_nxt;
    logic signed [15:0] hist_r [`MTC_HIST_DEPTH];

    // Converts a time in fine units to whole clock cycles, rounded down.
    function automatic logic [31:0] to_cycles(input logic [31:0] units, input int div);
        to_cycles = units / 32'(div);
    endfunction : to_cycles

    // True when the source is one of the level or pin sources.
    function automatic logic is_hw_src(input mtc_pkg::mtc_src_type s);
        is_hw_src = (s == mtc_pkg::SRC_EXT) || (s == mtc_pkg::SRC_CH1)
                    || (s == mtc_pkg::SRC_CH2);
    endfunction : is_hw_src

    // ------------------------------------------------------------------
    // Combinational next state
    // ------------------------------------------------------------------
    logic                 cmd_w;
    logic [31:0]          wd;
    logic signed [15:0]   pw;
    logic signed [15:0]   thr;
    logic                 above;
    logic                 below;
    logic                 lvl_event;
    logic                 trig;
    logic                 sweep;
    logic [31:0]          dly_mag;
    mtc_pkg::mtc_src_type new_src;

    always_comb begin
        s_nxt      = s_r;
        wd         = hwdata_i;
        s_nxt.start = 1'b0;
        // Pin synchroniser; the second stage and its delayed copy ext_d feed the edge detect.
        s_nxt.ext_s1 = ext_trig_i;
        s_nxt.ext_s2 = s_r.ext_s1;
        s_nxt.ext_d  = s_r.ext_s2;
        s_nxt.hist_ptr = s_r.hist_ptr + 6'h01;
        sweep = s_r.mode[`MTC_MODE_SWEEP];
        cmd_w = s_r.wr_pend && (s_r.wr_addr == `MTC_OFS_CMD);
        new_src = mtc_pkg::mtc_src_type'(wd[2:0]);

        // [R8] channel selection
        pw  = (s_r.src == mtc_pkg::SRC_CH2) ? power_i.ch2 : power_i.ch1;
        thr = 16'(({8'h00, s_r.hyst} + 16'h0001) >> 1);
        // [R21] hysteresis band
        above = pw > (s_r.level + thr);
        below = pw < (s_r.level - thr);
        // [R24] edge polarity
        lvl_event = 1'b0;
        if (s_r.mode[`MTC_MODE_SLOPE_NEG]) begin
            if (s_r.armed_edge && below) begin
                lvl_event = 1'b1;
            end
            if (above) begin
                s_nxt.armed_edge = 1'b1;
            end
        end else begin
            if (s_r.armed_edge && above) begin
                lvl_event = 1'b1;
            end
            if (below) begin
                s_nxt.armed_edge = 1'b1;
            end
        end
        if (lvl_event) begin
            s_nxt.armed_edge = 1'b0;
        end

        // Source qualification.
        trig = 1'b0;
        case (s_r.src)
            // [R7] always true
            mtc_pkg::SRC_ALWAYS: trig = 1'b1;
            // [R4] bus triggers
            mtc_pkg::SRC_BUS: trig = cmd_w && (wd[`MTC_CMD_GET] || wd[`MTC_CMD_TRG]);
            // [R5] external pin edge
            mtc_pkg::SRC_EXT: trig = s_r.ext_s2 && !s_r.ext_d;
            mtc_pkg::SRC_CH1,
            mtc_pkg::SRC_CH2: trig = lvl_event;
            // [R6] hold blocks all but immediate
            default: trig = 1'b0;
        endcase
        // [R26] [R20] holdoff gating
        if (s_r.hold_cnt != 32'h0 && !sweep) begin
            trig = 1'b0;
        end
        if (s_r.hold_cnt != 32'h0) begin
            s_nxt.hold_cnt = s_r.hold_cnt - 32'h1;
        end

        // Trigger state machine.
        dly_mag = s_r.delay[31] ? 32'(-s_r.delay) : 32'(s_r.delay);
        case (s_r.st)
            mtc_pkg::ST_IDLE: begin
                // [R25] continuous arms itself
                if (s_r.mode[`MTC_MODE_CONT]) begin
                    s_nxt.st = mtc_pkg::ST_WAIT;
                end
            end
            mtc_pkg::ST_WAIT: begin
                // [R1] immediate trigger fires
                if ((cmd_w && wd[`MTC_CMD_IMM]) || trig) begin
                    // [R19] holdoff from event
                    s_nxt.hold_cnt = to_cycles(s_r.holdoff, HLD_DIV);
                    s_nxt.tap = 6'h00;
                    s_nxt.cnt = 32'h0;
                    // [R17] [R18] delay load
                    if (!sweep && !(cmd_w && wd[`MTC_CMD_IMM])) begin
                        if (s_r.delay[31]) begin
                            // [R27] pretrigger tap
                            s_nxt.tap = 6'(to_cycles(dly_mag, DLY_DIV));
                        end else begin
                            s_nxt.cnt = to_cycles(dly_mag, DLY_DIV);
                        end
                    end
                    if (s_r.mode[`MTC_MODE_SETTLE] && !(cmd_w && wd[`MTC_CMD_IMM])) begin
                        s_nxt.cnt = s_nxt.cnt + 32'(`MTC_SETTLE_CYCLES);
                    end
                    s_nxt.st = mtc_pkg::ST_DELAY;
                end
            end
            mtc_pkg::ST_DELAY: begin
                if (s_r.cnt != 32'h0) begin
                    s_nxt.cnt = s_r.cnt - 32'h1;
                end else begin
                    s_nxt.start  = 1'b1;
                    s_nxt.sample = hist_r[s_r.hist_ptr - s_r.tap - 6'h01];
                    s_nxt.st     = mtc_pkg::ST_MEASURE;
                end
            end
            mtc_pkg::ST_MEASURE: begin
                if (meas_done_i) begin
                    s_nxt.stored = 1'b1;
                    // [R7] one shot returns idle
                    s_nxt.st = s_r.mode[`MTC_MODE_CONT] ? mtc_pkg::ST_WAIT : mtc_pkg::ST_IDLE;
                end
            end
            default: s_nxt.st = mtc_pkg::ST_IDLE;
        endcase

        // Register writes, taken in the cycle after the address phase.
        if (s_r.wr_pend) begin
            case (s_r.wr_addr)
                `MTC_OFS_CMD: begin
                    if (wd[`MTC_CMD_ARM] && s_r.st == mtc_pkg::ST_IDLE) begin
                        s_nxt.st = mtc_pkg::ST_WAIT;
                    end
                    // [R2] ignored trigger error
                    if (wd[`MTC_CMD_IMM] && s_r.st != mtc_pkg::ST_WAIT) begin
                        s_nxt.err = `MTC_ERR_TRIG_IGN;
                    end
                    // [R9] reset or local forces always
                    if (wd[`MTC_CMD_RESET] || wd[`MTC_CMD_LOCAL]) begin
                        s_nxt.src = mtc_pkg::SRC_ALWAYS;
                    end
                    if (wd[`MTC_CMD_RESET]) begin
                        s_nxt.delay   = `MTC_RST_DELAY;
                        s_nxt.holdoff = `MTC_RST_HOLDOFF;
                        s_nxt.hyst    = `MTC_RST_HYST;
                        s_nxt.level   = `MTC_RST_LEVEL;
                        s_nxt.mode    = 10'h004;
                    end
                    // [R10] measure or configure
                    if (wd[`MTC_CMD_MEASCONF]) begin
                        s_nxt.src = mtc_pkg::SRC_ALWAYS;
                    end
                    if (wd[`MTC_CMD_ERRCLR] && !(wd[`MTC_CMD_IMM]
                            && s_r.st != mtc_pkg::ST_WAIT)) begin
                        s_nxt.err = `MTC_ERR_NONE;
                    end
                end
                `MTC_OFS_SRC: begin
                    // [R13] master change while slaved
                    if (s_r.mode[`MTC_MODE_SLAVED] && !is_hw_src(new_src)) begin
                        s_nxt.err = `MTC_ERR_CONFLICT;
                    // [R14] adjacent mode mismatch
                    end else if (is_hw_src(new_src) && s_r.mode[`MTC_MODE_ADJ_EXTINT]
                            && (s_r.mode[`MTC_MODE_ADJ_AVG] != s_r.mode[`MTC_MODE_SENS_AVG])) begin
                        s_nxt.err = `MTC_ERR_CONFLICT;
                    // [R15] [R16] rate and detector
                    end else if (is_hw_src(new_src) && (s_r.mode[`MTC_MODE_RATE200]
                            || s_r.mode[`MTC_MODE_DET_AVG])) begin
                        s_nxt.err = `MTC_ERR_CONFLICT;
                    end else if (wd[2:0] <= 3'h5) begin
                        // [R3] select only, no arming
                        s_nxt.src = new_src;
                    end
                end
                `MTC_OFS_MODE:    s_nxt.mode = wd[9:0];
                `MTC_OFS_DELAY: begin
                    if ($signed(wd) <= `MTC_DELAY_MAX && $signed(wd) >= -`MTC_DELAY_MAX) begin
                        s_nxt.delay = $signed(wd);
                    end
                end
                `MTC_OFS_HOLDOFF: begin
                    if (wd >= `MTC_HOLDOFF_MIN && wd <= `MTC_HOLDOFF_MAX) begin
                        s_nxt.holdoff = wd;
                    end
                end
                `MTC_OFS_HYST: begin
                    if (wd[7:0] <= `MTC_HYST_MAX && wd[31:8] == 24'h0) begin
                        s_nxt.hyst = wd[7:0];
                    end
                end
                `MTC_OFS_LEVEL: begin
                    // [R22] threshold range
                    if ($signed(wd[15:0]) >= `MTC_LEVEL_MIN
                            && $signed(wd[15:0]) <= `MTC_LEVEL_MAX) begin
                        s_nxt.level = $signed(wd[15:0]);
                    end
                end
                `MTC_OFS_STATUS:  s_nxt.stored = s_r.st == mtc_pkg::ST_MEASURE && meas_done_i;
                default: ;
            endcase
        end

        // Bus address phase capture and read data.
        s_nxt.wr_pend = hsel_i && hready_i && htrans_i[1] && hwrite_i;
        s_nxt.wr_addr = haddr_i;
        if (hsel_i && hready_i && htrans_i[1] && !hwrite_i) begin
            case (haddr_i)
                // [R12] source query
                `MTC_OFS_SRC:     s_nxt.rdata = {29'h0, s_r.src};
                `MTC_OFS_MODE:    s_nxt.rdata = {22'h0, s_r.mode};
                `MTC_OFS_DELAY:   s_nxt.rdata = s_r.delay;
                `MTC_OFS_HOLDOFF: s_nxt.rdata = s_r.holdoff;
                `MTC_OFS_HYST:    s_nxt.rdata = {24'h0, s_r.hyst};
                `MTC_OFS_LEVEL:   s_nxt.rdata = {{16{s_r.level[15]}}, s_r.level};
                // [R23] settling enable readback
                `MTC_OFS_STATUS:  s_nxt.rdata = {27'h0, s_r.mode[`MTC_MODE_SETTLE],
                                                 s_r.stored, 1'b0, s_r.st};
                `MTC_OFS_ERROR:   s_nxt.rdata = {{16{s_r.err[15]}}, s_r.err};
                default:          s_nxt.rdata = 32'h0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            s_r         <= '0;
            s_r.src     <= mtc_pkg::SRC_ALWAYS;
            s_r.st      <= mtc_pkg::ST_IDLE;
            s_r.holdoff <= `MTC_RST_HOLDOFF;
            s_r.mode    <= 10'h004;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Pretrigger history; no reset, it only ever holds samples.
    always_ff @(posedge sys_clk_i) begin
        hist_r[s_r.hist_ptr] <= power_i.ch1;
    end

    assign hrdata_o      = s_r.rdata;
    assign hreadyout_o   = 1'b1;
    assign hresp_o       = 1'b0;
    assign meas_start_o  = s_r.start;
    assign meas_sample_o = s_r.sample;
    assign waiting_o     = (s_r.st == mtc_pkg::ST_WAIT);

endmodule : mtc_trigger

// ---- testbench/mtc_trigger_properties.sv ----
// Concurrent checks on the ports of the trigger control block.
// Assumes the bind at the foot attaches it to mtc_trigger.
`include "mtc_cfg.svh"

module mtc_chk (
    input wire logic        sys_clk_i,
    input wire logic        reset_i,
    input wire logic        hsel_i,
    input wire logic [11:0] haddr_i,
    input wire logic [1:0]  htrans_i,
    input wire logic        hwrite_i,
    input wire logic [31:0] hwdata_i,
    input wire logic        hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic        hreadyout_o,
    input wire logic        hresp_o,
    input wire logic        meas_start_o,
    input wire logic        waiting_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    // Address phase seen; the write data follows one cycle later.
    wire adr = hsel_i && hready_i && htrans_i[1];
    wire cmd = adr && hwrite_i && haddr_i == `MTC_OFS_CMD;

    a_src_no_arm: assert property (
        adr && hwrite_i && haddr_i == `MTC_OFS_SRC && !waiting_o |=> !waiting_o [*2])
        else $error("source write armed");
    a_arm_waits: assert property (
        cmd ##1 (hwdata_i[`MTC_CMD_ARM] && !waiting_o) |=> waiting_o)
        else $error("arm did not reach wait");
    a_imm_fires: assert property (
        cmd ##1 (hwdata_i[`MTC_CMD_IMM] && waiting_o) |-> ##[1:300] meas_start_o)
        else $error("immediate gave no start");
    a_reset_idle: assert property ($fell(reset_i) |-> !waiting_o && !meas_start_o)
        else $error("not idle after reset");
    a_start_single: assert property (meas_start_o |=> !meas_start_o)
        else $error("start too long");
    a_rdata_stands: assert property (!(adr && !hwrite_i) |=> $stable(hrdata_o))
        else $error("read data changed");
    a_ready_okay: assert property (hreadyout_o && !hresp_o)
        else $error("bus not okay");
    a_wait_to_start: assert property ($fell(waiting_o) |-> ##[0:300] meas_start_o)
        else $error("trigger without start");
endmodule : mtc_chk

bind mtc_trigger mtc_chk u_chk (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i),
    .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .meas_start_o(meas_start_o), .waiting_o(waiting_o));

// ---- testbench/mtc_meas_model.sv ----
// Measurement engine and signal source beside the trigger block.
// Assumes one-cycle start pulses on clk_i; latency is chosen per start.
module mtc_meas_model (
    input  wire logic                   clk_i,
    input  wire logic                   reset_i,
    input  wire logic                   start_i,
    input  wire logic [2:0]             lat_i,
    output logic                        done_o,
    output mtc_pkg::mtc_power_type      power_o
);
    int   cnt;
    logic up;

    // ----------------------------------------------------------------
    // Engine and source
    // ----------------------------------------------------------------
    // Channel one ramps through the level; channel two sits below it,
    // so only channel one ever crosses it.
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt <= -1;
            up <= 1'b1;
            done_o <= 1'b0;
            power_o <= {16'shFF38, 16'shFFCE};
        end else begin
            done_o <= (cnt == 0);
            cnt <= start_i ? int'(lat_i) : (cnt >= 0 ? cnt - 1 : -1);
            power_o.ch1 <= up ? power_o.ch1 + 16'sh0004 : power_o.ch1 - 16'sh0004;
            if (power_o.ch1 >= 16'sh00C4) up <= 1'b0;
            if (power_o.ch1 <= -16'sh00C4) up <= 1'b1;
        end
    end
endmodule : mtc_meas_model

// ---- testbench/measurement_trigger_control_bench.sv ----
// Self-checking bench for mtc_trigger: an AHB-Lite master, a read monitor
// fed by a queue of expectations, and the engine model on the far side.
`include "mtc_cfg.svh"

module measurement_trigger_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                   clk    = 1'b0;
    logic                   rst    = 1'b1;
    logic                   hsel   = 1'b0;
    logic                   hwrite = 1'b0;
    logic                   ext    = 1'b0;
    logic                   rph    = 1'b0;
    logic [11:0]            haddr  = 12'h000;
    logic [1:0]             htrans = 2'h0;
    logic [31:0]            hwdata = 32'h0000_0000;
    logic [2:0]             lat    = 3'h1;
    logic [31:0]            hrdata, exp_q[$], msk_q[$];
    logic                   hready, hresp, mstart, waiting, mdone;
    logic signed [15:0]     msamp, p1, p2;
    mtc_pkg::mtc_power_type pwr;
    int                     errors = 0, cmp_count = 0, seed = 92, n;

    always #20 clk = ~clk;

    mtc_trigger uut (.sys_clk_i(clk), .reset_i(rst), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
        .ext_trig_i(ext), .power_i(pwr), .meas_done_i(mdone), .meas_start_o(mstart),
        .meas_sample_o(msamp), .waiting_o(waiting));
    mtc_meas_model model (.clk_i(clk), .reset_i(rst), .start_i(mstart), .lat_i(lat),
        .done_o(mdone), .power_o(pwr));

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // One transfer; entered and left just after a rising edge.
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
    endtask : bus

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        bus(1'b0, a, 32'h0000_0000);
    endtask : rd

    // Counts starts over c cycles; fresh engine latency.
    task automatic see(input int c, output int s);
        s = 0;
        lat <= 3'($random(seed));
        repeat (c) begin
            @(posedge clk);
            if (mstart === 1'b1) s++;
        end
    endtask : see

    // Arm, send a command, expect starts or none.
    task automatic fire(input logic [31:0] c, input int cyc, input logic exp);
        bus(1'b1, `MTC_OFS_CMD, 32'h0000_0001);
        bus(1'b1, `MTC_OFS_CMD, c);
        see(cyc, n);
        chk(32'(n != 0), {31'h0, exp});
    endtask : fire

    // Read data are compared at the edge that ends their data phase.
    always @(posedge clk) begin
        if (rph && exp_q.size() > 0) chk(hrdata & msk_q.pop_front(), exp_q.pop_front());
        rph = hsel && htrans[1] && !hwrite && hready;
        {p2, p1} <= {p1, pwr.ch1};
        if (mstart === 1'b1) chk(32'(msamp), 32'(p2));
    end

    initial begin
        #800000;
        errors++;
        end_sim();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] mv[4] = '{32'h10, 32'h20, 32'h200, 32'h180};
        logic [31:0] sv[4] = '{32'h3, 32'h4, 32'h1, 32'h3};
        logic [31:0] cv[3] = '{32'h40, 32'h10, 32'h20};
        logic [31:0] lv;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(`MTC_OFS_SRC, 32'h0, 32'hFFFF_FFFF);
        rd(`MTC_OFS_MODE, 32'h4, 32'hFFFF_FFFF);
        rd(`MTC_OFS_DELAY, 32'h0, 32'hFFFF_FFFF);
        rd(`MTC_OFS_HOLDOFF, `MTC_RST_HOLDOFF, 32'hFFFF_FFFF);
        rd(`MTC_OFS_HYST, 32'h0, 32'hFF);
        rd(`MTC_OFS_LEVEL, 32'h0, 32'hFFFF);
        bus(1'b1, `MTC_OFS_MODE, 32'h0);
        rd(`MTC_OFS_MODE, 32'h0, 32'h4);
        bus(1'b1, `MTC_OFS_CMD, 32'h2);
        rd(`MTC_OFS_ERROR, 32'hFF2D, 32'hFFFF);
        // Each conflict must refuse the new source.
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, `MTC_OFS_CMD, 32'h80);
            bus(1'b1, `MTC_OFS_MODE, mv[k]);
            bus(1'b1, `MTC_OFS_SRC, sv[k]);
            rd(`MTC_OFS_SRC, 32'h0, 32'h7);
            rd(`MTC_OFS_ERROR, 32'hFF23, 32'hFFFF);
        end
        bus(1'b1, `MTC_OFS_MODE, 32'h0);
        bus(1'b1, `MTC_OFS_CMD, 32'h80);
        bus(1'b1, `MTC_OFS_SRC, 32'h2);
        rd(`MTC_OFS_SRC, 32'h2, 32'h7);
        chk({31'h0, waiting}, 32'h0);
        fire(32'hC, 60, 1'b0);
        chk({31'h0, waiting}, 32'h1);
        bus(1'b1, `MTC_OFS_CMD, 32'h2);
        see(300, n);
        chk(32'(n), 32'h1);
        rd(`MTC_OFS_STATUS, 32'h8, 32'h8);
        bus(1'b1, `MTC_OFS_SRC, 32'h1);
        fire(32'h4, 300, 1'b1);
        fire(32'h8, 300, 1'b1);
        fire(32'h2, 300, 1'b1);
        bus(1'b1, `MTC_OFS_SRC, 32'h3);
        fire(32'h0, 60, 1'b0);
        ext <= 1'b1;
        see(300, n);
        ext <= 1'b0;
        chk(32'(n), 32'h1);
        bus(1'b1, `MTC_OFS_SRC, 32'h5);
        fire(32'h0, 300, 1'b0);
        bus(1'b1, `MTC_OFS_CMD, 32'h2);
        see(300, n);
        bus(1'b1, `MTC_OFS_SRC, 32'h4);
        fire(32'h0, 400, 1'b1);
        bus(1'b1, `MTC_OFS_SRC, 32'h0);
        fire(32'h0, 300, 1'b1);
        chk({31'h0, waiting}, 32'h0);
        bus(1'b1, `MTC_OFS_MODE, 32'h1);
        see(600, n);
        chk(32'(n > 1), 32'h1);
        bus(1'b1, `MTC_OFS_MODE, 32'h0);
        see(300, n);
        // Each command forces the source back.
        for (int k = 0; k < 3; k++) begin
            bus(1'b1, `MTC_OFS_SRC, 32'h3);
            bus(1'b1, `MTC_OFS_CMD, cv[k]);
            rd(`MTC_OFS_SRC, 32'h0, 32'h7);
        end
        lv = 32'($signed($random(seed) % 200));
        bus(1'b1, `MTC_OFS_LEVEL, lv);
        rd(`MTC_OFS_LEVEL, lv, 32'hFFFF);
        bus(1'b1, `MTC_OFS_HOLDOFF, `MTC_HOLDOFF_MAX);
        rd(`MTC_OFS_HOLDOFF, `MTC_HOLDOFF_MAX, 32'hFFFF_FFFF);
        repeat (2) @(posedge clk);
        end_sim();
    end
endmodule : measurement_trigger_control_bench
